// ### psq_regs.svh
/*
 * Register offsets, reset values, phase numbers and flag positions
 * of the program sequencer.
 * Assumes a byte-addressed APB with 32-bit words, one word per register.
 */
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PSQ_OFS_CLB   8'h00
`define PSQ_OFS_TBLO  8'h04
`define PSQ_OFS_TBHI  8'h08
`define PSQ_OFS_THR   8'h0C
`define PSQ_OFS_STAT  8'h10

// ****************************************
// Reset values
// ****************************************
`define PSQ_RST_PC    11'h000
`define PSQ_LVL_EMPTY 3'h0

// ****************************************
// Instruction phases T1..T4
// ****************************************
`define PSQ_PH_T1     2'h0
`define PSQ_PH_T2     2'h1
`define PSQ_PH_T4     2'h3

// ****************************************
// Status flag bit positions
// ****************************************
`define PSQ_F_C       0
`define PSQ_F_AC      1
`define PSQ_F_Z       2
`define PSQ_F_OV      3

// ****************************************
// Decimal adjust constants
// ****************************************
`define PSQ_DAA_LO    8'h06
`define PSQ_DAA_HI    8'h60
`define PSQ_BCD_MAX   4'h9

`endif

// ### psq_pkg.sv
/*
 * Types shared by the program sequencer and its decoder:
 * execution commands and ALU operations.
 * Assumes nothing of its surroundings.
 */
package psq_pkg;

  // ****************************************
  // Command of the instruction in execution
  // ****************************************
  typedef enum logic [3:0] {
    PSQ_CMD_NONE,
    PSQ_CMD_JUMP,
    PSQ_CMD_CALL,
    PSQ_CMD_RET,
    PSQ_CMD_IRET,
    PSQ_CMD_SKIP,
    PSQ_CMD_TABRD,
    PSQ_CMD_TABRD_LAST,
    PSQ_CMD_ALU
  } psq_cmd_t;

  // ****************************************
  // ALU operations
  // ****************************************
  typedef enum logic [4:0] {
    PSQ_OP_ADD, PSQ_OP_ADC, PSQ_OP_SUB, PSQ_OP_SBC,
    PSQ_OP_DAA, PSQ_OP_AND, PSQ_OP_OR,  PSQ_OP_XOR,
    PSQ_OP_CPL, PSQ_OP_RL,  PSQ_OP_RLC, PSQ_OP_RR,
    PSQ_OP_RRC, PSQ_OP_INC, PSQ_OP_DEC, PSQ_OP_SZ,
    PSQ_OP_SIZ, PSQ_OP_SDZ
  } psq_op_t;

endpackage

// ### psq_sequencer.sv
/*
 * Program sequencer: program counter, return stack, interrupt
 * acknowledge, table read path, ALU and APB register slave.
 * Assumes a program memory that returns the addressed word one clock
 * after the address, and a decoder that holds its command, operands
 * and destination stable for the whole instruction cycle.
 */
// Local design decisions: register access over APB and the register addresses.
// How it works
// [RL1] Counter steps by one unless redirected
// [RL2] Only counter low byte is software visible
// [RL3] Low byte write jumps within page
// [RL4] Low byte write adds one dummy cycle
// [RL5] Branches, interrupts, reset load full target
// [RL6] True skip replaces prefetched instruction with dummy
// [RL7] Four-entry stack, hidden from software
// [RL8] Call and interrupt acknowledge push counter
// [RL9] Both returns pop into counter
// [RL10] Reset sets stack level to empty
// [RL11] Full stack holds interrupt until return
// [RL12] Call on full stack drops oldest
// [RL13] ALU writes result and updates flags
// [RL14] Full arithmetic, logic, rotate, skip set
// [RL15] Program store 2K words of 16
// [RL16] Execution starts at address zero
// [RL17] Table read splits word into two bytes
// [RL18] Unused table high bits read zero
// [RL19] Table high register ignores writes
// [RL20] Table read lasts two instruction cycles
// [RL21] Four phases form one instruction cycle
// [RL22] Jump and call take two cycles
// [RL23] Last-page table read ignores high pointer
`timescale 1ns/1ps
`default_nettype none
`include "psq_regs.svh"

module psq_sequencer #(
  parameter int AW     = 11,
  parameter int PMEM_W = 16,
  parameter int DEPTH  = 4
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic      [AW-1:0]     pmem_addr_o,
  input  wire logic [PMEM_W-1:0] pmem_data_i,
  output logic      [PMEM_W-1:0] instr_o,
  output logic                   instr_valid_o,
  output logic      [1:0]        phase_o,
  input  wire psq_pkg::psq_cmd_t cmd_i,
  input  wire logic [AW-1:0]     target_i,
  input  wire logic              skip_cond_i,
  input  wire psq_pkg::psq_op_t  alu_op_i,
  input  wire logic [7:0]        alu_a_i,
  input  wire logic [7:0]        alu_b_i,
  input  wire logic [7:0]        dest_i,
  output logic      [7:0]        wr_data_o,
  output logic      [7:0]        wr_dest_o,
  output logic                   wr_en_o,
  output logic      [3:0]        flags_o,
  input  wire logic              irq_req_i,
  input  wire logic [AW-1:0]     irq_vector_i,
  output logic                   irq_ack_o
);
  import psq_pkg::*;

  localparam int HW    = AW - 8;
  localparam int LVL_W = $clog2(DEPTH + 1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]              phase;
    logic [AW-1:0]           pc;
    logic [AW-1:0]           addr;
    logic [PMEM_W-1:0]       fetch;
    logic [PMEM_W-1:0]       instr;
    logic                    ivalid;
    logic [DEPTH-1:0][AW-1:0] stk;
    logic [LVL_W-1:0]        lvl;
    logic                    irq_pend;
    logic                    irq_ack;
    logic [3:0]              stat;
    logic [7:0]              wr_data;
    logic [7:0]              wr_dest;
    logic                    wr_en;
    logic                    clb_pend;
    logic [7:0]              clb_val;
    logic [7:0]              tblp;
    logic [HW-1:0]           tbhp;
    logic [7:0]              thr;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } psq_state_t;

  psq_state_t state_q;
  psq_state_t state_d;

  // ****************************************
  // Working signals of the next-state logic
  // ****************************************
  psq_cmd_t          cmd;
  logic              bound;
  logic              redir;
  logic              is_tab;
  logic [AW-1:0]     pc_nx;
  logic [AW-1:0]     tab_addr;
  logic [7:0]        bb;
  logic              cin;
  logic [8:0]        sum9;
  logic [4:0]        sum5;
  logic [7:0]        res;
  logic [7:0]        adj;
  logic              zskip;
  logic              apb_wr;

  // Register outputs straight from the state
  assign prdata_o      = state_q.prdata;
  assign pready_o      = state_q.pready;
  assign pslverr_o     = state_q.pslverr;
  assign pmem_addr_o   = state_q.addr;          // [RL15]
  assign instr_o       = state_q.instr;
  assign instr_valid_o = state_q.ivalid;
  assign phase_o       = state_q.phase;
  assign wr_data_o     = state_q.wr_data;
  assign wr_dest_o     = state_q.wr_dest;
  assign wr_en_o       = state_q.wr_en;
  assign flags_o       = state_q.stat;
  assign irq_ack_o     = state_q.irq_ack;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_d  = state_q;
    cmd      = state_q.ivalid ? cmd_i : PSQ_CMD_NONE;
    bound    = (state_q.phase == `PSQ_PH_T4);
    redir    = 1'h0;
    pc_nx    = AW'(state_q.pc + 1'h1);          // [RL1]
    is_tab   = (cmd == PSQ_CMD_TABRD) || (cmd == PSQ_CMD_TABRD_LAST);
    tab_addr = {state_q.tbhp, state_q.tblp};
    bb       = alu_b_i;
    cin      = 1'h0;
    sum9     = 9'h000;
    sum5     = 5'h00;
    res      = alu_a_i;
    adj      = 8'h00;
    zskip    = 1'h0;
    apb_wr   = psel_i & penable_i & state_q.pready & pwrite_i;

    // One-cycle strobes fall by default
    state_d.pready  = 1'h0;
    state_d.pslverr = 1'h0;
    state_d.wr_en   = 1'h0;
    state_d.irq_ack = 1'h0;

    // Four phases per instruction cycle
    state_d.phase = 2'(state_q.phase + 2'h1);   // [RL21]

    // Last page is the all-ones page of the store
    if (cmd == PSQ_CMD_TABRD_LAST) begin
      tab_addr = {{HW{1'h1}}, state_q.tblp};     // [RL23]
    end

    // Sequential word captured in T2, table address then issued
    if (state_q.phase == `PSQ_PH_T2) begin
      state_d.fetch = pmem_data_i;
      if (is_tab) begin
        state_d.addr = tab_addr;                 // [RL17]
      end
    end

    // ALU datapath, subtraction as add of inverted operand
    unique case (alu_op_i)
      PSQ_OP_SUB: begin
        bb  = ~alu_b_i;
        cin = 1'h1;
      end
      PSQ_OP_SBC: begin
        bb  = ~alu_b_i;
        cin = state_q.stat[`PSQ_F_C];
      end
      PSQ_OP_ADC: begin
        cin = state_q.stat[`PSQ_F_C];
      end
      default: begin
        bb  = alu_b_i;
        cin = 1'h0;
      end
    endcase
    sum9 = {1'h0, alu_a_i} + {1'h0, bb} + {8'h00, cin};
    sum5 = {1'h0, alu_a_i[3:0]} + {1'h0, bb[3:0]} + {4'h0, cin};

    // Instruction boundary at the end of T4
    if (bound) begin
      unique case (cmd)
        PSQ_CMD_NONE: begin
        end
        PSQ_CMD_JUMP: begin
          pc_nx = target_i;                      // [RL5]
          redir = 1'h1;                          // [RL22]
        end
        PSQ_CMD_CALL: begin
          for (int i = DEPTH - 1; i > 0; i--) begin
            state_d.stk[i] = state_q.stk[i-1];   // [RL12]
          end
          state_d.stk[0] = state_q.pc;           // [RL8]
          if (state_q.lvl != LVL_FULL) begin
            state_d.lvl = LVL_W'(state_q.lvl + 1'h1);
          end
          pc_nx = target_i;                      // [RL5]
          redir = 1'h1;                          // [RL22]
        end
        PSQ_CMD_RET, PSQ_CMD_IRET: begin
          pc_nx = state_q.stk[0];                // [RL9]
          for (int i = 0; i < DEPTH - 1; i++) begin
            state_d.stk[i] = state_q.stk[i+1];
          end
          if (state_q.lvl != `PSQ_LVL_EMPTY) begin
            state_d.lvl = LVL_W'(state_q.lvl - 1'h1);
          end
          redir = 1'h1;
        end
        PSQ_CMD_SKIP: begin
          redir = skip_cond_i;                   // [RL6]
        end
        PSQ_CMD_TABRD, PSQ_CMD_TABRD_LAST: begin
          // Low byte to the named register, high byte kept here
          state_d.wr_data = pmem_data_i[7:0];    // [RL17]
          state_d.wr_dest = dest_i;
          state_d.wr_en   = 1'h1;
          state_d.thr     = 8'(pmem_data_i[PMEM_W-1:8]); // [RL18]
          // Refetch the same address: second cycle is a dummy
          pc_nx = state_q.pc;                    // [RL20]
          redir = 1'h1;
        end
        PSQ_CMD_ALU: begin
          // Operation select and flag update
          unique case (alu_op_i)
            PSQ_OP_ADD, PSQ_OP_ADC, PSQ_OP_SUB, PSQ_OP_SBC: begin
              res = sum9[7:0];                   // [RL14]
              state_d.stat[`PSQ_F_C]  = sum9[8]; // [RL13]
              state_d.stat[`PSQ_F_AC] = sum5[4];
              state_d.stat[`PSQ_F_OV] = (alu_a_i[7] == bb[7]) &&
                                        (sum9[7] != alu_a_i[7]);
              state_d.stat[`PSQ_F_Z]  = (sum9[7:0] == 8'h00);
            end
            PSQ_OP_DAA: begin
              if (alu_a_i[3:0] > `PSQ_BCD_MAX ||
                  state_q.stat[`PSQ_F_AC]) begin
                adj = adj | `PSQ_DAA_LO;
              end
              if (alu_a_i[7:4] > `PSQ_BCD_MAX ||
                  state_q.stat[`PSQ_F_C]) begin
                adj = adj | `PSQ_DAA_HI;
                state_d.stat[`PSQ_F_C] = 1'h1;
              end
              res = 8'(alu_a_i + adj);
            end
            PSQ_OP_AND: begin
              res = alu_a_i & alu_b_i;
              state_d.stat[`PSQ_F_Z] = (res == 8'h00);
            end
            PSQ_OP_OR: begin
              res = alu_a_i | alu_b_i;
              state_d.stat[`PSQ_F_Z] = (res == 8'h00);
            end
            PSQ_OP_XOR: begin
              res = alu_a_i ^ alu_b_i;
              state_d.stat[`PSQ_F_Z] = (res == 8'h00);
            end
            PSQ_OP_CPL: begin
              res = ~alu_a_i;
              state_d.stat[`PSQ_F_Z] = (res == 8'h00);
            end
            PSQ_OP_RL: begin
              res = {alu_a_i[6:0], alu_a_i[7]};
            end
            PSQ_OP_RLC: begin
              res = {alu_a_i[6:0], state_q.stat[`PSQ_F_C]};
              state_d.stat[`PSQ_F_C] = alu_a_i[7];
            end
            PSQ_OP_RR: begin
              res = {alu_a_i[0], alu_a_i[7:1]};
            end
            PSQ_OP_RRC: begin
              res = {state_q.stat[`PSQ_F_C], alu_a_i[7:1]};
              state_d.stat[`PSQ_F_C] = alu_a_i[0];
            end
            PSQ_OP_INC: begin
              res = 8'(alu_a_i + 8'h01);
              state_d.stat[`PSQ_F_Z] = (res == 8'h00);
            end
            PSQ_OP_DEC: begin
              res = 8'(alu_a_i - 8'h01);
              state_d.stat[`PSQ_F_Z] = (res == 8'h00);
            end
            PSQ_OP_SZ: begin
              res   = alu_a_i;
              zskip = 1'h1;
            end
            PSQ_OP_SIZ: begin
              res   = 8'(alu_a_i + 8'h01);
              zskip = 1'h1;
            end
            PSQ_OP_SDZ: begin
              res   = 8'(alu_a_i - 8'h01);
              zskip = 1'h1;
            end
            default: begin
              res = alu_a_i;
            end
          endcase
          state_d.wr_data = res;                 // [RL13]
          state_d.wr_dest = dest_i;
          state_d.wr_en   = 1'h1;
          redir = zskip && (res == 8'h00);       // [RL6]
        end
        default: begin
        end
      endcase

      // Low byte write: jump inside the current page, one dummy cycle
      if (state_q.clb_pend) begin
        pc_nx = {state_q.pc[AW-1:8], state_q.clb_val}; // [RL3]
        redir = 1'h1;                            // [RL4]
        state_d.clb_pend = 1'h0;
      end

      // Acknowledge only with a free level; otherwise keep pending
      if (!redir && state_q.irq_pend &&
          state_q.lvl != LVL_FULL) begin         // [RL11]
        for (int i = DEPTH - 1; i > 0; i--) begin
          state_d.stk[i] = state_q.stk[i-1];
        end
        state_d.stk[0]   = state_q.pc;           // [RL8]
        state_d.lvl      = LVL_W'(state_q.lvl + 1'h1);
        pc_nx            = irq_vector_i;         // [RL5]
        redir            = 1'h1;
        state_d.irq_ack  = 1'h1;
        state_d.irq_pend = 1'h0;
      end

      // Hand over the prefetched word, or a dummy on redirect
      state_d.pc     = pc_nx;                    // [RL1]
      state_d.addr   = pc_nx;
      state_d.instr  = state_q.fetch;
      state_d.ivalid = !redir;                   // [RL22]
    end

    // A request arriving with an acknowledge is kept
    if (irq_req_i) begin
      state_d.irq_pend = 1'h1;                   // [RL11]
    end

    // APB setup phase: answer in the access phase
    if (psel_i && !penable_i) begin
      state_d.pready  = 1'h1;
      state_d.pslverr = 1'h0;
      state_d.prdata  = 32'h0000_0000;
      case (paddr_i)
        `PSQ_OFS_CLB:  state_d.prdata = {24'h000000, state_q.pc[7:0]}; // [RL2]
        `PSQ_OFS_TBLO: state_d.prdata = {24'h000000, state_q.tblp};
        `PSQ_OFS_TBHI: state_d.prdata = 32'(state_q.tbhp);
        `PSQ_OFS_THR:  state_d.prdata = {24'h000000, state_q.thr};
        `PSQ_OFS_STAT: state_d.prdata = {28'h0000000, state_q.stat};
        default:       state_d.pslverr = 1'h1;  // [RL7]
      endcase
    end

    // APB write takes effect at the completing edge
    if (apb_wr) begin
      case (paddr_i)
        `PSQ_OFS_CLB: begin
          state_d.clb_pend = 1'h1;               // [RL3]
          state_d.clb_val  = pwdata_i[7:0];
        end
        `PSQ_OFS_TBLO: state_d.tblp = pwdata_i[7:0];
        `PSQ_OFS_TBHI: state_d.tbhp = pwdata_i[HW-1:0];
        `PSQ_OFS_THR:  state_d.thr  = state_q.thr; // [RL19]
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q       <= '0;
      state_q.phase <= `PSQ_PH_T1;
      state_q.pc    <= `PSQ_RST_PC;              // [RL16]
      state_q.addr  <= `PSQ_RST_PC;              // [RL5]
      state_q.lvl   <= `PSQ_LVL_EMPTY;           // [RL10]
    end else begin
      state_q <= state_d;
    end
  end

endmodule
`default_nettype wire

// ### psq_sequencer_asserts.sv
/* Port checker of the program sequencer.
   Assumes it is bound to psq_sequencer, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer_asserts #(
  parameter int AW     = 11,
  parameter int PMEM_W = 16,
  parameter int DEPTH  = 4
) (
  input wire logic              ref_clk_i,
  input wire logic              sys_rst_i,
  input wire logic [7:0]        paddr_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic [AW-1:0]     pmem_addr_o,
  input wire logic [PMEM_W-1:0] pmem_data_i,
  input wire logic [PMEM_W-1:0] instr_o,
  input wire logic              instr_valid_o,
  input wire logic [1:0]        phase_o,
  input wire psq_pkg::psq_cmd_t cmd_i,
  input wire logic [AW-1:0]     target_i,
  input wire logic              skip_cond_i,
  input wire logic [7:0]        dest_i,
  input wire logic [7:0]        wr_data_o,
  input wire logic [7:0]        wr_dest_o,
  input wire logic              wr_en_o,
  input wire logic              irq_ack_o,
  input wire logic [AW-1:0]     irq_vector_i
);
  import psq_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ******
  // Instruction boundary and dummy cycle
  // ******
  sequence s_exec(psq_cmd_t c);
    phase_o == 2'h3 && instr_valid_o && cmd_i == c;
  endsequence
  sequence s_dummy;
    (!instr_valid_o) [*4];
  endsequence

  // ******
  // Properties
  // ******
  a_phase_ring: assert property (!$past(sys_rst_i) |-> phase_o == $past(phase_o) + 2'h1)
    else $error("phase does not cycle");
  a_instr_hold: assert property (phase_o != 2'h0 |-> $stable(instr_o))
    else $error("instruction changed inside a cycle");
  a_seq_step: assert property (s_exec(PSQ_CMD_NONE) ##1 instr_valid_o
    |-> pmem_addr_o == $past(pmem_addr_o) + 1'b1) else $error("counter did not step by one");
  a_jump_load: assert property (s_exec(PSQ_CMD_JUMP)
    |=> pmem_addr_o == $past(target_i) && !instr_valid_o) else $error("jump target wrong");
  a_skip_dummy: assert property (s_exec(PSQ_CMD_SKIP) ##0 skip_cond_i |=> s_dummy)
    else $error("true skip without dummy");
  a_alu_write: assert property (s_exec(PSQ_CMD_ALU)
    |=> wr_en_o && wr_dest_o == $past(dest_i) ##1 !wr_en_o) else $error("alu write wrong");
  a_table_word: assert property (s_exec(PSQ_CMD_TABRD)
    |=> (wr_en_o && {8'h00, wr_data_o} == ($past(pmem_data_i) & 16'h00FF)) ##0 s_dummy)
    else $error("table low byte wrong");
  a_last_page: assert property (phase_o == 2'h1 && instr_valid_o
    && cmd_i == PSQ_CMD_TABRD_LAST |=> pmem_addr_o[AW-1:AW-3] == 3'h7)
    else $error("last page read off page");
  a_ack_vector: assert property (irq_ack_o
    |-> pmem_addr_o == $past(irq_vector_i) && !instr_valid_o) else $error("vector not loaded");
  a_low_width: assert property (pready_o && paddr_i == 8'h00 |-> prdata_o[31:8] == 24'h0)
    else $error("counter high bits visible");
  a_bad_addr: assert property (pready_o && paddr_i > 8'h10 |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
endmodule

bind psq_sequencer psq_sequencer_asserts #(.AW(AW), .PMEM_W(PMEM_W), .DEPTH(DEPTH))
  u_psq_sequencer_asserts (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pmem_addr_o(pmem_addr_o),
  .pmem_data_i(pmem_data_i), .instr_o(instr_o), .instr_valid_o(instr_valid_o),
  .phase_o(phase_o), .cmd_i(cmd_i), .target_i(target_i), .skip_cond_i(skip_cond_i),
  .dest_i(dest_i), .wr_data_o(wr_data_o), .wr_dest_o(wr_dest_o), .wr_en_o(wr_en_o),
  .irq_ack_o(irq_ack_o), .irq_vector_i(irq_vector_i));
`default_nettype wire

// ### psq_prog_mem.sv
/* Program store model: 2K words of 16 bits, word = marker and address.
   Assumes the sequencer reads data one clock after the address. */
`timescale 1ns/1ps
`default_nettype none
module psq_prog_mem #(
  parameter int AW = 11
) (
  input  wire logic          clk_i,
  input  wire logic [AW-1:0] addr_i,
  output logic      [15:0]   data_o
);
  // Registered read, every word names its own address
  always_ff @(posedge clk_i) begin
    data_o <= {5'h15, addr_i};
  end
endmodule
`default_nettype wire

// ### psq_sequencer_tb.sv
/* Self-checking bench of the program sequencer.
   Assumes the program store model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer_tb;
  import psq_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, skip_cond_i;
  logic instr_valid_o, wr_en_o, irq_req_i, irq_ack_o, err;
  logic [7:0] paddr_i, alu_a_i, alu_b_i, dest_i, wr_data_o, wr_dest_o, wr_dat;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [10:0] pmem_addr_o, target_i, irq_vector_i;
  logic [15:0] pmem_data_i, instr_o, got;
  logic [1:0] phase_o;
  logic [3:0] flags_o;
  psq_cmd_t cmd_i;
  psq_op_t alu_op_i;
  int fail_count = 0, tests_run = 0, ack_cnt = 0, dum;

  // Clock 40 MHz
  always #12.5 ref_clk_i = ~ref_clk_i;

  psq_sequencer u_psq_sequencer (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pmem_addr_o(pmem_addr_o), .pmem_data_i(pmem_data_i), .instr_o(instr_o),
    .instr_valid_o(instr_valid_o), .phase_o(phase_o), .cmd_i(cmd_i), .target_i(target_i),
    .skip_cond_i(skip_cond_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i),
    .dest_i(dest_i), .wr_data_o(wr_data_o), .wr_dest_o(wr_dest_o), .wr_en_o(wr_en_o),
    .flags_o(flags_o), .irq_req_i(irq_req_i), .irq_vector_i(irq_vector_i),
    .irq_ack_o(irq_ack_o));
  psq_prog_mem u_psq_prog_mem (.clk_i(ref_clk_i), .addr_i(pmem_addr_o), .data_o(pmem_data_i));

  // Count acknowledges and keep the last register write
  always @(posedge ref_clk_i) begin
    if (irq_ack_o === 1'b1) ack_cnt++;
    if (wr_en_o === 1'b1) wr_dat = wr_data_o;
  end

  // ******
  // Helpers
  // ******
  function automatic logic [15:0] w(input logic [10:0] a);
    return {5'h15, a};
  endfunction
  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string m);
    tests_run++;
    if (act !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, act, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 16) begin chk(0, 1, "apb timeout"); test_done; end
    rd = prdata_o; err = pslverr_o; psel_i <= 1'b0; penable_i <= 1'b0;
  endtask
  // Issue one command for the next valid instruction, counting dummies
  task automatic step(input psq_cmd_t c, input logic [10:0] t, input logic sc);
    int n;
    dum = 0;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk_i);
      if (phase_o == 2'h0 && instr_valid_o === 1'b1) break;
      if (phase_o == 2'h0) dum++;
    end
    if (n == 40) begin chk(0, 1, "step timeout"); test_done; end
    got = instr_o; cmd_i <= c; target_i <= t; skip_cond_i <= sc;
    for (n = 0; n < 4; n++) begin
      @(posedge ref_clk_i);
      if (phase_o == 2'h3) break;
    end
    cmd_i <= PSQ_CMD_NONE; skip_cond_i <= 1'b0;
  endtask
  task automatic seek(input logic [15:0] e);
    for (int k = 0; k < 4; k++) begin
      step(PSQ_CMD_NONE, 11'h0, 1'b0);
      if (got === e) break;
    end
    chk(got, e, "redirect target");
  endtask
  task automatic alu(input psq_op_t op, input logic [7:0] a, b, r);
    alu_op_i <= op; alu_a_i <= a; alu_b_i <= b;
    step(PSQ_CMD_ALU, 11'h0, 1'b0);
    repeat (2) @(posedge ref_clk_i);
    chk(wr_dat, r, "alu result");
  endtask

  // ******
  // Main sequence
  // ******
  initial begin
    sys_rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = 8'h00;
    pwdata_i = 32'h0; cmd_i = PSQ_CMD_NONE; target_i = 11'h0; skip_cond_i = 1'b0;
    alu_op_i = PSQ_OP_ADD; alu_a_i = 8'h00; alu_b_i = 8'h00; dest_i = 8'h5A;
    irq_req_i = 1'b0; irq_vector_i = 11'h004; got = 16'h0;
    repeat (16) @(posedge ref_clk_i);
    chk(pmem_addr_o, 0, "reset address");
    sys_rst_i <= 1'b0;
    step(PSQ_CMD_NONE, 11'h0, 1'b0); chk(got, w(11'h000), "first word");
    step(PSQ_CMD_JUMP, 11'h123, 1'b0); chk(got, w(11'h001), "next word");
    step(PSQ_CMD_SKIP, 11'h0, 1'b0); chk(got, w(11'h123), "jump"); chk(dum, 1, "jump");
    step(PSQ_CMD_SKIP, 11'h0, 1'b1); chk(dum, 0, "false skip");
    step(PSQ_CMD_NONE, 11'h0, 1'b0); chk(got, w(11'h126), "true skip"); chk(dum, 1, "sk");
    $display("test branch done");
    apb(1'b1, 8'h00, 32'h0000_0040);
    seek(w(11'h140)); chk(dum, 1, "low byte write dummy");
    apb(1'b0, 8'h00, 32'h0); chk(rd[31:8], 0, "counter high hidden");
    step(PSQ_CMD_CALL, 11'h200, 1'b0);
    step(PSQ_CMD_RET, 11'h0, 1'b0); chk(got, w(11'h200), "call");
    step(PSQ_CMD_CALL, 11'h300, 1'b0); chk(got, w(11'h143), "return");
    step(PSQ_CMD_CALL, 11'h400, 1'b0);
    step(PSQ_CMD_CALL, 11'h500, 1'b0);
    step(PSQ_CMD_CALL, 11'h600, 1'b0);
    irq_req_i <= 1'b1;
    @(posedge ref_clk_i);
    irq_req_i <= 1'b0;
    step(PSQ_CMD_NONE, 11'h0, 1'b0);
    step(PSQ_CMD_RET, 11'h0, 1'b0); chk(ack_cnt, 0, "ack while full");
    seek(w(11'h004)); chk(ack_cnt, 1, "pending served");
    step(PSQ_CMD_IRET, 11'h0, 1'b0);
    step(PSQ_CMD_NONE, 11'h0, 1'b0);
    chk(got, w(11'h501), "interrupt return");
    $display("test stack done");
    alu(PSQ_OP_ADD, 8'h80, 8'h80, 8'h00); chk(flags_o, 4'hD, "add flags");
    alu(PSQ_OP_ADC, 8'h01, 8'h01, 8'h03);
    alu(PSQ_OP_SUB, 8'h05, 8'h05, 8'h00); chk({flags_o[2], flags_o[0]}, 2'b11, "sub");
    alu(PSQ_OP_SBC, 8'h05, 8'h01, 8'h04);
    alu(PSQ_OP_AND, 8'h96, 8'h0F, 8'h06);
    alu(PSQ_OP_OR, 8'h96, 8'h0F, 8'h9F);
    alu(PSQ_OP_XOR, 8'h96, 8'h0F, 8'h99);
    alu(PSQ_OP_CPL, 8'h96, 8'h96, 8'h69);
    alu(PSQ_OP_INC, 8'h96, 8'h96, 8'h97);
    alu(PSQ_OP_DEC, 8'h96, 8'h96, 8'h95);
    alu(PSQ_OP_RL, 8'h96, 8'h96, 8'h2D);
    alu(PSQ_OP_RR, 8'h96, 8'h96, 8'h4B);
    alu(PSQ_OP_RLC, 8'h96, 8'h96, 8'h2D);
    alu(PSQ_OP_RRC, 8'h96, 8'h96, 8'hCB);
    alu(PSQ_OP_DAA, 8'h1A, 8'h1A, 8'h20);
    alu(PSQ_OP_SIZ, 8'hFF, 8'hFF, 8'h00);
    chk(instr_valid_o, 0, "skip on zero");
    $display("test alu done");
    apb(1'b1, 8'h04, 32'h06); apb(1'b1, 8'h08, 32'h07);
    step(PSQ_CMD_TABRD, 11'h0, 1'b0);
    step(PSQ_CMD_NONE, 11'h0, 1'b0); chk(dum, 1, "table two cycles");
    chk(wr_dat, 8'h06, "table low byte");
    apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'hAF, "table high byte");
    apb(1'b1, 8'h0C, 32'h0); apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'hAF, "read only");
    apb(1'b1, 8'h08, 32'h02); apb(1'b1, 8'h04, 32'h05);
    step(PSQ_CMD_TABRD_LAST, 11'h0, 1'b0);
    step(PSQ_CMD_NONE, 11'h0, 1'b0); chk(wr_dat, 8'h05, "last page low");
    apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'hAF, "last page high");
    apb(1'b0, 8'h14, 32'h0); chk(err, 1, "unmapped"); chk(rd, 0, "unmapped data");
    $display("test table done");
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    step(PSQ_CMD_NONE, 11'h0, 1'b0); chk(got, w(11'h000), "restart");
    $display("test reset done");
    test_done;
  end
endmodule
`default_nettype wire
